// *** rtl/adcctl_pkg.sv ***
// Functional notes
// - interrupts off: flag sets each single conversion, only first in continuous; read-only.
// - writing status/control or reading result clears the completion flag.
// - interrupts on: flag becomes writable; software clears it to service request.
// - reset clears the completion flag.
// - enable bit set raises interrupt request at each conversion end; reset clears enable.
// - result read or status/control write drops the interrupt request.
// - continuous bit set keeps converting back to back, updating result each time.
// - continuous bit clear gives one conversion per status/control write; reset clears it.
// - five-bit channel select routes eight external inputs or internal references.
// - all-ones channel code powers the converter down; no conversions happen.
// - undefined channel codes give a meaningless result value.
// - one eight-bit result register, loaded at every conversion end.
// - three-bit prescaler divides by 1, 2, 4, 8, or 16 when top bit set.
// - clock source bit one picks bus clock, zero picks oscillator clock.
// - reset selects the oscillator clock as converter input clock.
// - conversion starts after status/control write and lasts 16 to 17 converter clocks.
// - continuous mode overwrites result whether or not it was read.
// - stop mode aborts pending conversion; after stop exits only a status/control write starts a new one.
package adcctl_pkg;
  localparam logic [1:0] ADDR_STATUS_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_RESULT = 2'h1;
  localparam logic [1:0] ADDR_CLOCK_SELECT = 2'h2;
  localparam int BIT_DONE = 7;
  localparam int BIT_IRQ_EN = 6;
  localparam int BIT_CONT = 5;
  localparam int BIT_CLK_SRC = 4;
  localparam int PRESC_MSB = 7;
  localparam int PRESC_LSB = 5;
  localparam logic [4:0] CHAN_POWER_OFF = 5'h1F;
  localparam logic [4:0] CHAN_REF_LOW = 5'h1E;
  localparam logic [4:0] CHAN_REF_HIGH = 5'h1D;
  localparam logic [4:0] CHAN_EXT_LAST = 5'h07;
  localparam logic [4:0] CHAN_RESET = 5'h1F;
  localparam logic [7:0] CLKSEL_RESET = 8'h00;
  localparam logic [3:0] DIV_MAX_M1 = 4'hF;
  localparam logic [1:0] CNT_MAX = 2'h3;

  typedef struct packed {
    logic start;
    logic [4:0] channel;
    logic power_down;
    logic conv_clk_en;
  } adcctl_core_req_s;

  typedef struct packed {
    logic done;
    logic [7:0] result;
  } adcctl_core_rsp_s;
endpackage

// *** rtl/adcctl_prescaler.sv ***
`timescale 1ns/100ps
`default_nettype none
module adcctl_prescaler (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_src_en,
  input wire logic [2:0] i_div_code,
  output logic o_tick
);
  import adcctl_pkg::*;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [3:0] limit;
  logic wrap;

  // top bit set means divide by sixteen regardless of the low bits
  assign limit = i_div_code[2] ? DIV_MAX_M1 : 4'((4'h1 << i_div_code[1:0]) - 4'h1);
  assign wrap = i_src_en && (cnt_q >= limit);
  assign cnt_d = wrap ? 4'h0 : (i_src_en ? 4'(cnt_q + 4'h1) : cnt_q);
  assign o_tick = wrap;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule
`default_nettype wire

// *** rtl/adcctl_top.sv ***
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module adcctl_top (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic [1:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  input wire logic i_bus_clk_en,
  input wire logic i_oscillator_clock_en,
  input wire logic i_stop_mode,
  output adcctl_pkg::adcctl_core_req_s o_core_req,
  input wire adcctl_pkg::adcctl_core_rsp_s i_core_rsp,
  output logic o_done_irq
);
  import adcctl_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_START = 3'b010,
    ST_CONV = 3'b100
  } adcctl_state_e;

  adcctl_state_e state_q;
  adcctl_state_e state_d;
  logic conversion_done_flag_q;
  logic done_irq_enable_q;
  logic continuous_mode_bit_q;
  logic [4:0] channel_select_q;
  logic [7:0] conv_result_q;
  logic [7:0] conv_clock_select_q;
  logic [7:0] rdata_q;
  logic first_done_q;
  logic irq_q;
  logic [1:0] tick_cnt_q;

  wire wr_scr = i_reg_wr && (i_reg_addr == ADDR_STATUS_CONTROL);
  wire wr_clk = i_reg_wr && (i_reg_addr == ADDR_CLOCK_SELECT);
  wire rd_res = i_reg_rd && (i_reg_addr == ADDR_RESULT);
  wire powered_off = (channel_select_q == CHAN_POWER_OFF);
  wire clock_source_bit = conv_clock_select_q[BIT_CLK_SRC];
  wire [2:0] clock_prescaler = conv_clock_select_q[PRESC_MSB:PRESC_LSB];
  wire src_en = clock_source_bit ? i_bus_clk_en : i_oscillator_clock_en;
  wire conv_tick;
  wire core_done = (state_q == ST_CONV) && i_core_rsp.done;
  wire halt = i_stop_mode || powered_off;
  wire new_powered_off = (i_reg_wdata[4:0] == CHAN_POWER_OFF);
  // a completion sets the flag in single mode, only the first one in continuous mode
  wire done_set = core_done && !halt && (!continuous_mode_bit_q || !first_done_q);
  // software may write the flag only while interrupts are enabled
  wire flag_sw_val = done_irq_enable_q ? i_reg_wdata[BIT_DONE] : 1'b0;

  adcctl_prescaler adcctl_prescaler_inst (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_src_en(src_en),
    .i_div_code(clock_prescaler),
    .o_tick(conv_tick)
  );

  // a tick can only come on a pulse of src_en, the mux output itself, so this checks the prescaler and not which source the mux picked
  tick_src_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    conv_tick |-> src_en)
    else $error("converter tick without source enable");
  div_one_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (clock_prescaler == 3'h0) && src_en |-> conv_tick)
    else $error("divide by one skipped a source pulse");

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (wr_scr && !new_powered_off && !i_stop_mode) begin
          state_d = ST_START;
        end
      end
      ST_START: begin
        if (halt) begin
          state_d = ST_IDLE;
        end else if (conv_tick) begin
          state_d = ST_CONV;
        end
      end
      ST_CONV: begin
        if (halt) begin
          state_d = ST_IDLE;
        end else if (wr_scr) begin
          state_d = ST_START;
        end else if (i_core_rsp.done) begin
          state_d = continuous_mode_bit_q ? ST_START : ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      state_q <= ST_IDLE;
    end else if (wr_scr && i_stop_mode) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // the core times a conversion itself; stop and power-off drop the state and raise power_down to abort it
  conv_enter_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (state_q == ST_START) && conv_tick && !halt |=> state_q == ST_CONV)
    else $error("start tick did not enter conversion");
  idle_hold_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (state_q == ST_IDLE) && !wr_scr |=> state_q == ST_IDLE)
    else $error("conversion began without a status write");
  power_idle_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    powered_off && !wr_scr |=> state_q == ST_IDLE)
    else $error("converter busy while powered off");

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      done_irq_enable_q <= 1'b0;
      continuous_mode_bit_q <= 1'b0;
      channel_select_q <= CHAN_RESET;
      conv_clock_select_q <= CLKSEL_RESET;
    end else begin
      if (wr_scr) begin
        done_irq_enable_q <= i_reg_wdata[BIT_IRQ_EN];
        continuous_mode_bit_q <= i_reg_wdata[BIT_CONT];
        channel_select_q <= i_reg_wdata[4:0];
      end
      if (wr_clk) begin
        conv_clock_select_q <= {i_reg_wdata[7:4], 4'h0};
      end
    end
  end

  // reset values are checked with reset itself, so these are not disabled by it
  ctrl_reset_a: assert property (@(posedge i_core_clk)
    i_sys_rst |=> !done_irq_enable_q && !continuous_mode_bit_q && powered_off)
    else $error("control fields not cleared by reset");
  clk_reset_a: assert property (@(posedge i_core_clk)
    i_sys_rst |=> !clock_source_bit)
    else $error("reset did not select the oscillator clock");

  // set beats clear when a completion meets a clearing access
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      conversion_done_flag_q <= 1'b0;
    end else if (done_set) begin
      conversion_done_flag_q <= 1'b1;
    end else if (wr_scr) begin
      conversion_done_flag_q <= flag_sw_val;
    end else if (rd_res) begin
      conversion_done_flag_q <= 1'b0;
    end
  end

  // clear paths are a status write and a result read; a completion that sets the flag wins
  flag_reset_a: assert property (@(posedge i_core_clk)
    i_sys_rst |=> !conversion_done_flag_q && !o_done_irq)
    else $error("reset left the completion flag set");
  flag_ro_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    wr_scr && !done_irq_enable_q && !done_set |=> !conversion_done_flag_q)
    else $error("flag written while interrupts disabled");
  flag_write_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    wr_scr && done_irq_enable_q && !done_set |=> conversion_done_flag_q == $past(i_reg_wdata[BIT_DONE]))
    else $error("flag write ignored while interrupts enabled");
  flag_hold_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !done_set && !wr_scr && !rd_res |=> $stable(conversion_done_flag_q))
    else $error("flag changed without cause");
  cont_first_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    core_done && continuous_mode_bit_q && first_done_q && !wr_scr && !rd_res |=> $stable(conversion_done_flag_q))
    else $error("flag set again in continuous mode");

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      first_done_q <= 1'b0;
    end else if (wr_scr) begin
      first_done_q <= 1'b0;
    end else if (core_done && !halt) begin
      first_done_q <= 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      irq_q <= 1'b0;
    end else if (core_done && !halt && done_irq_enable_q) begin
      irq_q <= 1'b1;
    end else if (wr_scr || rd_res) begin
      irq_q <= 1'b0;
    end
  end

  // the request is a level, so software polling late still sees it
  irq_hold_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    o_done_irq && !wr_scr && !rd_res |=> o_done_irq)
    else $error("interrupt dropped without a clearing access");

  // result is taken as given, even for undefined channel codes
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      conv_result_q <= 8'h00;
    end else if (core_done && !halt) begin
      conv_result_q <= i_core_rsp.result;
    end
  end

  // unread results are overwritten on purpose; there is no overrun flag
  result_hold_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !(core_done && !halt) |=> $stable(conv_result_q))
    else $error("result changed without a completion");

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      tick_cnt_q <= 2'h0;
    end else if (state_q != ST_CONV) begin
      tick_cnt_q <= 2'h0;
    end else if (conv_tick && tick_cnt_q != CNT_MAX) begin
      tick_cnt_q <= 2'(tick_cnt_q + 2'h1);
    end
  end

  // the core times the conversion itself; this guards against a completion arriving
  // before the divided clock has run, which would mean a stale start was taken
  conv_ticks_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    core_done |-> tick_cnt_q == CNT_MAX)
    else $error("completion before the converter clock ran");

  wire [7:0] scr_view = {conversion_done_flag_q, done_irq_enable_q, continuous_mode_bit_q, channel_select_q};
  wire [7:0] rd_mux = (i_reg_addr == ADDR_STATUS_CONTROL) ? scr_view :
                      (i_reg_addr == ADDR_RESULT) ? conv_result_q :
                      (i_reg_addr == ADDR_CLOCK_SELECT) ? conv_clock_select_q : 8'h00;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      rdata_q <= 8'h00;
    end else if (i_reg_rd) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // idle zeros keep a stale value from being taken for a late read
  rdata_idle_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !i_reg_rd |=> o_reg_rdata == 8'h00)
    else $error("read data outside the read cycle");

  assign o_reg_rdata = rdata_q;
  assign o_done_irq = irq_q;
  assign o_core_req = '{
    start: (state_q == ST_START) && conv_tick && !halt,
    channel: channel_select_q,
    power_down: halt,
    conv_clk_en: conv_tick && !halt
  };

  start_qual_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    o_core_req.start |-> o_core_req.conv_clk_en && (o_core_req.channel == channel_select_q))
    else $error("start pulse without a converter clock");

  irq_drop_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (wr_scr || rd_res) && !(core_done && !halt) |=> !o_done_irq)
    else $error("interrupt stayed up after clearing access");
  irq_raise_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    core_done && !halt && done_irq_enable_q |=> o_done_irq)
    else $error("interrupt not raised at conversion end");
  flag_clr_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    rd_res && !done_set |=> !conversion_done_flag_q)
    else $error("flag survived result read");
  flag_set_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    done_set |=> conversion_done_flag_q)
    else $error("flag not set at conversion end");
  result_load_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    core_done && !halt |=> conv_result_q == $past(i_core_rsp.result))
    else $error("result not loaded");
  power_off_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    powered_off |-> !o_core_req.start)
    else $error("start while powered off");
  stop_abort_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_stop_mode && !wr_scr |=> state_q == ST_IDLE)
    else $error("conversion not aborted in stop mode");
  cont_restart_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    core_done && !halt && continuous_mode_bit_q && !wr_scr |=> state_q == ST_START)
    else $error("continuous mode did not restart");
  single_idle_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    core_done && !halt && !continuous_mode_bit_q && !wr_scr |=> state_q == ST_IDLE)
    else $error("single mode converted again");
  read_data_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_reg_rd && i_reg_addr == ADDR_RESULT |=> o_reg_rdata == $past(conv_result_q))
    else $error("result read data wrong");

  single_cov: cover property (@(posedge i_core_clk) wr_scr ##[1:400] core_done);
  cont_cov: cover property (@(posedge i_core_clk) core_done && continuous_mode_bit_q ##[1:400] core_done);
  irq_cov: cover property (@(posedge i_core_clk) o_done_irq ##1 rd_res);
  stop_cov: cover property (@(posedge i_core_clk) state_q == ST_CONV ##1 i_stop_mode);
  presc_cov: cover property (@(posedge i_core_clk) conv_tick && clock_prescaler[2]);
endmodule
`default_nettype wire

// *** test/adcctl_core_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module adcctl_core_model (
  input wire logic i_core_clk,
  input wire logic i_slow,
  input wire adcctl_pkg::adcctl_core_req_s i_req,
  output adcctl_pkg::adcctl_core_rsp_s o_rsp
);
  import adcctl_pkg::*;
  logic [4:0] ticks_q = 5'h00;
  logic [7:0] seq_q = 8'h00;
  logic busy_q = 1'b0;
  initial o_rsp = '0;
  always @(posedge i_core_clk) begin
    o_rsp.done <= 1'b0;
    // result lines carry nothing outside done, so never hold the old value
    o_rsp.result <= ~o_rsp.result;
    if (i_req.power_down) begin
      busy_q <= 1'b0;
    end else if (i_req.start && i_req.conv_clk_en) begin
      busy_q <= 1'b1;
      ticks_q <= 5'h01;
    end else if (busy_q && i_req.conv_clk_en) begin
      ticks_q <= ticks_q + 5'h01;
      if (ticks_q == (i_slow ? 5'h10 : 5'h0F)) begin
        busy_q <= 1'b0;
        o_rsp.done <= 1'b1;
        o_rsp.result <= {i_req.channel[2:0], seq_q[4:0]};
        seq_q <= seq_q + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// *** test/adcctl_top_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module adcctl_top_tb;
  import adcctl_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic bus_en = 1'b0;
  logic osc_en = 1'b0;
  logic stop = 1'b0;
  logic slow = 1'b0;
  logic [7:0] rdata;
  logic irq;
  adcctl_core_req_s req;
  adcctl_core_rsp_s rsp;
  logic [7:0] last_res = 8'h00;
  logic [7:0] d;
  int n_errors = 0;
  int compares = 0;
  int n_done = 0;
  int n0;
  int ph = 0;
  int per;
  logic [7:0] row_sel [8] = '{8'h00, 8'h30, 8'h20, 8'h40, 8'h60, 8'h80, 8'hE0, 8'h10};
  int row_per [8] = '{2, 6, 4, 8, 16, 32, 32, 3};

  adcctl_top adcctl_top_inst (.i_core_clk(clk), .i_sys_rst(rst), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_bus_clk_en(bus_en), .i_oscillator_clock_en(osc_en),
    .i_stop_mode(stop), .o_core_req(req), .i_core_rsp(rsp), .o_done_irq(irq));
  adcctl_core_model adcctl_core_model_inst (.i_core_clk(clk), .i_slow(slow), .i_req(req), .o_rsp(rsp));

  always #2.5 clk = ~clk;
  // oscillator every 2nd cycle, bus every 3rd, so the two sources differ
  always @(posedge clk) begin
    ph <= ph + 1;
    osc_en <= (ph % 2 == 1);
    bus_en <= (ph % 3 == 2);
    if (rsp.done === 1'b1) begin
      last_res <= rsp.result;
      n_done <= n_done + 1;
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [1:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_conv;
    int k;
    for (k = 0; k < 3000 && rsp.done !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    check({7'h0, rsp.done}, 8'h01);
    repeat (2) @(posedge clk);
  endtask
  task automatic tick_gap;
    int k;
    for (k = 0; k < 200 && req.conv_clk_en !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    for (per = 1; per < 200 && req.conv_clk_en !== 1'b1; per++) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic give_verdict;
    if (n_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #400000;
    n_errors++;
    give_verdict();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd_reg(2'h0);
    check(d, 8'h1F);
    rd_reg(2'h2);
    check(d, 8'h00);
    rd_reg(2'h3);
    check(d, 8'h00);
    check({7'h0, req.power_down}, 8'h01);
    // leaving power-off: one throwaway conversion before results are trusted
    wr_reg(2'h0, 8'h00);
    wait_conv();
    for (int i = 0; i < 8; i++) begin
      slow <= i[0];
      wr_reg(2'h2, row_sel[i]);
      rd_reg(2'h2);
      check(d, row_sel[i] & 8'hF0);
      wr_reg(2'h0, 8'(i));
      // the first gap after a divider change may be short, so time the second
      tick_gap();
      tick_gap();
      check(8'(per), 8'(row_per[i]));
      check({3'h0, req.channel}, 8'(i));
      wait_conv();
      rd_reg(2'h0);
      check(d, 8'h80 | 8'(i));
      rd_reg(2'h1);
      check(d, last_res);
      rd_reg(2'h0);
      check(d, 8'(i));
    end
    wr_reg(2'h1, 8'h5A);
    rd_reg(2'h1);
    check(d, last_res);
    wr_reg(2'h0, 8'h43);
    wait_conv();
    check({7'h0, irq}, 8'h01);
    rd_reg(2'h1);
    check({7'h0, irq}, 8'h00);
    wr_reg(2'h0, 8'hC3);
    rd_reg(2'h0);
    check(d, 8'hC3);
    wait_conv();
    check({7'h0, irq}, 8'h01);
    wr_reg(2'h0, 8'h03);
    #1 check({7'h0, irq}, 8'h00);
    tick_gap();
    n0 = n_done;
    @(posedge clk);
    stop <= 1'b1;
    repeat (300) @(posedge clk);
    check({7'h0, req.power_down}, 8'h01);
    check(8'(n_done - n0), 8'h00);
    stop <= 1'b0;
    wr_reg(2'h0, 8'h03);
    wait_conv();
    rd_reg(2'h0);
    check(d, 8'h83);
    wr_reg(2'h0, 8'h22);
    wait_conv();
    rd_reg(2'h0);
    check(d, 8'hA2);
    wait_conv();
    rd_reg(2'h1);
    check(d, last_res);
    wait_conv();
    rd_reg(2'h0);
    check(d, 8'h22);
    wr_reg(2'h0, 8'h1F);
    n0 = n_done;
    repeat (300) @(posedge clk);
    check(8'(n_done - n0), 8'h00);
    // reset in mid-run with the interrupt pending and a non-default clock
    wr_reg(2'h2, 8'h30);
    wr_reg(2'h0, 8'h43);
    wait_conv();
    check({7'h0, irq}, 8'h01);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_reg(2'h0);
    check(d, 8'h1F);
    check({7'h0, irq}, 8'h00);
    rd_reg(2'h2);
    check(d, 8'h00);
    give_verdict();
  end
endmodule
`default_nettype wire
